// ===== power_sleep_module_gating_tb.sv
// Self-checking bench of the power and sleep controller
module power_sleep_module_gating_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cpu_idle, cpu_local_rst_n, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, access_req0, access_req1, access_ack0, access_ack1, rd;
  logic [31:0] mod_clk_en0, mod_rst_n0, mod_clk_en1, mod_rst_n1;
  logic [1:0] ram_sleep_mode0, ram_sleep_mode1;
  logic [31:0] used [2] = '{32'h0000_7EFF, 32'h0732_3DEA};
  logic [31:0] restr [2] = '{32'h0000_1C80, 32'h0700_0000};
  logic [31:0] e_clk [2];
  logic [31:0] e_rst [2];
  logic [2:0] e_code [2][32];
  logic [31:0] seed = 32'hDEF271C9;
  logic err;
  bit ok;
  int n_errors = 0;
  int samples_checked = 0;
  pss_ctrl dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .access_req0, .access_req1, .cpu_idle, .mod_clk_en0, .mod_rst_n0, .mod_clk_en1,
    .mod_rst_n1, .access_ack0, .access_ack1, .cpu_local_rst_n, .ram_sleep_mode0,
    .ram_sleep_mode1, .irq);
  pss_periph_model peer_u (.pclk, .access_ack0, .access_ack1, .access_req0, .access_req1,
    .cpu_idle);
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [1:0] cr_of(input logic [2:0] c);
    case (c)
      3'h0: return 2'b00;
      3'h1: return 2'b10;
      3'h3: return 2'b11;
      default: return 2'b01;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle();
    int n;
    n = 0;
    do begin
      apb(1'b0, pss_pkg::BUSY_STAT_OFS, 32'h0);
      n++;
    end while (rd[1:0] !== 2'b00 && n < 20);
    chk("busy", 32'h0, rd);
  endtask
  // Local reset bit kept at one so the processor is not disturbed
  task automatic set_mod(input int b, input int s, input logic [2:0] c);
    logic [2:0] e;
    apb(1'b1, pss_pkg::MOD_CTL_BASE + 12'(b * 256 + s * 4), {23'h0, 1'b1, 5'h0, c});
    e = (c > 3'h5) ? e_code[b][s] : c;
    if (!used[b][s]) e = 3'h0;
    else if (restr[b][s] && e < 3'h3) e = 3'h3;
    e_code[b][s] = e;
    {e_clk[b][s], e_rst[b][s]} = cr_of(e);
    settle();
    chk("clk_en", e_clk[b], (b == 0) ? mod_clk_en0 : mod_clk_en1);
    chk("rst_n", e_rst[b], (b == 0) ? mod_rst_n0 : mod_rst_n1);
    apb(1'b0, pss_pkg::MOD_STAT_BASE + 12'(b * 256 + s * 4), 32'h0);
    chk("status", {29'h0, e}, rd);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // Tests
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    presetn = 1'b0;
    e_clk = '{32'h0000_1CC0, 32'h0700_0000};
    e_rst = e_clk;
    foreach (e_code[b, s]) e_code[b][s] = e_clk[b][s] ? 3'h3 : 3'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk("clk_en0", e_clk[0], mod_clk_en0);
    chk("rst_n0", e_rst[0], mod_rst_n0);
    chk("clk_en1", e_clk[1], mod_clk_en1);
    chk("rst_n1", e_rst[1], mod_rst_n1);
    apb(1'b0, pss_pkg::DOMAIN_CTL1_OFS, 32'h0);
    chk("domain_on", 32'h100, rd & 32'h100);
    apb(1'b1, pss_pkg::DOMAIN_CTL1_OFS, 32'h1);
    apb(1'b0, 12'h020, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    chk("ram_mode1", 32'h1, {30'h0, ram_sleep_mode1});
    chk("ram_mode0", 32'h0, {30'h0, ram_sleep_mode0});
    $display("test defaults done");
    for (int c = 0; c < 8; c++) set_mod(1, 3, 3'(c));
    set_mod(0, 7, 3'h0);
    set_mod(1, 25, 3'h1);
    set_mod(0, 8, 3'h3);
    repeat (60) begin
      seed = lfsr(seed);
      set_mod(int'(seed[5]), int'(seed[4:0]), seed[8:6]);
    end
    $display("test states done");
    set_mod(0, 4, 3'h0);
    apb(1'b1, pss_pkg::INT_STAT_OFS, 32'h3);
    apb(1'b1, pss_pkg::INT_MASK_OFS, 32'h1);
    set_mod(1, 5, 3'h3);
    chk("irq_masked", 32'h0, {31'h0, irq});
    set_mod(0, 4, 3'h3);
    chk("irq_set", 32'h1, {31'h0, irq});
    apb(1'b1, pss_pkg::INT_STAT_OFS, 32'h1);
    apb(1'b0, pss_pkg::INT_STAT_OFS, 32'h0);
    chk("irq_clr", 32'h0, {31'h0, irq});
    $display("test interrupt done");
    set_mod(1, 3, 3'h4);
    peer_u.access(1, 3, 2, ok);
    chk("sleep_ack", 32'h1, {31'h0, ok});
    repeat (3) @(posedge pclk);
    chk("sleep_clk", 32'h0, {31'h0, mod_clk_en1[3]});
    set_mod(1, 6, 3'h5);
    peer_u.access(1, 6, 0, ok);
    repeat (3) @(posedge pclk);
    chk("wake_clk", 32'h1, {31'h0, mod_clk_en1[6]});
    apb(1'b0, pss_pkg::MOD_STAT_BASE + 12'h118, 32'h0);
    chk("wake_stat", 32'h3, rd);
    $display("test auto done");
    peer_u.set_idle(1'b0);
    apb(1'b1, pss_pkg::MOD_CTL_BASE + 12'h038, 32'h0000_0003);
    repeat (5) @(posedge pclk);
    chk("local_reset_bit_hold", 32'h1, {31'h0, cpu_local_rst_n});
    peer_u.set_idle(1'b1);
    for (int i = 0; i < 8 && cpu_local_rst_n !== 1'b0; i++) @(posedge pclk);
    chk("local_reset_bit_on", 32'h0, {31'h0, cpu_local_rst_n});
    apb(1'b1, pss_pkg::MOD_CTL_BASE + 12'h038, 32'h0000_0103);
    repeat (2) @(posedge pclk);
    chk("local_reset_bit_off", 32'h1, {31'h0, cpu_local_rst_n});
    $display("test local reset done");
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    end_of_test();
  end
endmodule // power_sleep_module_gating_tb

// ===== pss_ctrl.sv
// Power and sleep controller top: APB registers, interrupt, two slot banks
// Operation
// RULE_01: Every controlled module has its own local slot driving clock enable and reset.
// RULE_02: Global part holds registers, interrupt and one state machine per slot.
// RULE_03: Software switches module clocks, module resets and processor local reset.
// RULE_04: Controller holds the sleep mode of the RAM pseudo domain.
// RULE_05: Two controller instances, each with always-on and RAM pseudo domain.
// RULE_06: All domains are on after power-up; pseudo domains cannot lose power.
// RULE_07: Modules without a slot are not governed here.
// RULE_08: First instance slots 0-5, 9, 13, 14 start in reset with clock off.
// RULE_09: First instance slots 6, 7 start enabled; 7 restricted; 8, 15 unused.
// RULE_10: First instance slots 10-12 start enabled and are restricted.
// RULE_11: Second instance listed slots start in reset with clock off.
// RULE_12: Second instance slots 24-26 start enabled, restricted; others unused.
// RULE_13: Slot state maps to module reset and clock per the state table.
// RULE_14: Restricted slots turn disable or reset requests into enable.
// RULE_15: Auto sleep clocks only for an access; auto wake stays on after one.
// RULE_16: Local reset bit 0 asserts processor reset after outstanding work; 1 releases.
// RULE_17: Unused slots drive nothing, read zero and ignore writes.
// RULE_18: Clock enable and reset change in different cycles.
module pss_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] access_req0,
  input wire logic [31:0] access_req1,
  input wire logic cpu_idle,
  output logic [31:0] mod_clk_en0,
  output logic [31:0] mod_rst_n0,
  output logic [31:0] mod_clk_en1,
  output logic [31:0] mod_rst_n1,
  output logic [31:0] access_ack0,
  output logic [31:0] access_ack1,
  output logic cpu_local_rst_n,
  output logic [1:0] ram_sleep_mode0,
  output logic [1:0] ram_sleep_mode1,
  output logic irq
);

  localparam int unsigned NC = pss_pkg::NUM_CTRL;
  localparam int unsigned NS = pss_pkg::NUM_SLOTS;

  typedef logic [NC-1:0][NS-1:0][2:0] pss_tgt_t;

  typedef struct packed {
    pss_tgt_t tgt;
    logic local_reset_bit;
    logic cpu_rst_n;
    logic [NC-1:0][1:0] ram_mode;
    logic [NC-1:0] int_stat;
    logic [NC-1:0] int_mask;
    logic [NC-1:0] busy_prev;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic irq;
  } pss_ctrl_st_t;

  // ==========================================================
  // Helpers
  // Per slot lookups return one bit; a select on a call result is not portable
  function automatic logic used_slot(input int unsigned c, input int unsigned s);
    logic [31:0] m;
    m = (c == 0) ? pss_pkg::USED_MASK0 : pss_pkg::USED_MASK1;
    return m[s];
  endfunction

  function automatic logic on_slot(input int unsigned c, input int unsigned s);
    logic [31:0] m;
    m = (c == 0) ? pss_pkg::ON_MASK0 : pss_pkg::ON_MASK1;
    return m[s];
  endfunction

  function automatic logic restrict_slot(input int unsigned c, input int unsigned s);
    logic [31:0] m;
    m = (c == 0) ? pss_pkg::RESTRICT_MASK0 : pss_pkg::RESTRICT_MASK1;
    return m[s];
  endfunction

  function automatic pss_tgt_t reset_targets();
    pss_tgt_t t;
    t = '0;
    for (int c = 0; c < NC; c++) begin
      for (int s = 0; s < NS; s++) begin
        if (on_slot(c, s)) begin
          t[c][s] = pss_pkg::PSS_ENABLE;
        end else begin
          t[c][s] = pss_pkg::PSS_RST_CLK_OFF;
        end
      end
    end
    return t;
  endfunction

  // Decodes a slot window: returns hit, controller and slot index
  function automatic logic slot_hit(input logic [11:0] a, input logic [11:0] base,
                                    output logic c, output logic [4:0] s);
    c = a[8];
    s = a[6:2];
    return ((a & pss_pkg::WINDOW_MASK) == base) && (a[7] == 1'b0) && (a[1:0] == 2'h0)
      && used_slot(32'(a[8]), 32'(a[6:2]));
  endfunction

  localparam pss_ctrl_st_t RESET_VAL = '{tgt: reset_targets(), local_reset_bit: 1'b1,
    cpu_rst_n: 1'b0, ram_mode: {NC{pss_pkg::RAM_MODE_RESET}}, int_stat: '0,
    int_mask: '0, busy_prev: '0, rdata: '0, ready: 1'b0, err: 1'b0, irq: 1'b0};

  pss_ctrl_st_t st_reg, st_next;
  logic [NC-1:0][NS-1:0] s_clk, s_rst_n, s_busy, s_ack, s_req;
  logic [NC-1:0][NS-1:0][2:0] s_cur;
  logic [NC-1:0] busy_any;
  logic ctl_hit, stat_hit, ctl_c, stat_c;
  logic [4:0] ctl_s, stat_s;
  logic [2:0] wr_state;
  logic access_done;

  assign s_req[0] = access_req0;
  assign s_req[1] = access_req1;

  // ==========================================================
  // Slot banks, one state machine per used slot
  for (genvar c = 0; c < NC; c++) begin : g_ctrl
    for (genvar s = 0; s < NS; s++) begin : g_slot
      if (used_slot(c, s)) begin : g_used
        pss_slot #(
          .DEFAULT_ON(on_slot(c, s))
        ) u_slot (
          .pclk(pclk),
          .presetn(presetn),
          .target(st_reg.tgt[c][s]),
          .access_req(s_req[c][s]),
          .clk_en(s_clk[c][s]),
          .mod_rst_n(s_rst_n[c][s]),
          .cur_state(s_cur[c][s]),
          .busy(s_busy[c][s]),
          .access_ack(s_ack[c][s])
        ); // [RULE_01] [RULE_02]
      end else begin : g_unused
        // No module behind this slot
        assign s_clk[c][s] = 1'b0; // [RULE_07] [RULE_17]
        assign s_rst_n[c][s] = 1'b0;
        assign s_cur[c][s] = 3'h0;
        assign s_busy[c][s] = 1'b0;
        assign s_ack[c][s] = 1'b0;
      end
    end
    assign busy_any[c] = |s_busy[c];
  end

  if (NC != 2 || NS != 32) begin : g_check
    $error("pss_ctrl serves exactly two banks of 32 slots");
  end

  // ==========================================================
  // Register file and APB slave
  always_comb begin
    st_next = st_reg;
    ctl_hit = slot_hit(paddr, pss_pkg::MOD_CTL_BASE, ctl_c, ctl_s);
    stat_hit = slot_hit(paddr, pss_pkg::MOD_STAT_BASE, stat_c, stat_s);
    access_done = psel && penable && st_reg.ready;
    wr_state = pwdata[2:0];
    // Restricted slots never enter the reset or disable states; reset and disable writes become enable
    if (ctl_hit && restrict_slot(32'(ctl_c), 32'(ctl_s))
        && wr_state <= pss_pkg::PSS_DISABLE) begin
      wr_state = pss_pkg::PSS_ENABLE; // [RULE_14] [RULE_10] [RULE_12]
    end
    // Event: a bank finished its last pending transition
    for (int c = 0; c < NC; c++) begin
      if (st_reg.busy_prev[c] && !busy_any[c]) begin
        st_next.int_stat[c] = 1'b1;
      end
    end
    st_next.busy_prev = busy_any;
    st_next.ready = psel && penable && !st_reg.ready;
    st_next.err = 1'b0;
    if (psel && penable && !st_reg.ready) begin
      st_next.rdata = '0;
      st_next.err = 1'b1;
      // Used slot windows also match the unused window catch below;
      // the first matching item wins, so the catch serves empty slots and window offsets with bit 7 or bits 1:0 set
      priority case (1'b1)
        paddr == pss_pkg::INT_STAT_OFS: begin
          st_next.rdata = 32'(st_reg.int_stat);
          st_next.err = 1'b0;
        end
        paddr == pss_pkg::INT_MASK_OFS: begin
          st_next.rdata = 32'(st_reg.int_mask);
          st_next.err = 1'b0;
        end
        paddr == pss_pkg::BUSY_STAT_OFS: begin
          st_next.rdata = 32'(busy_any);
          st_next.err = 1'b0;
        end
        paddr == pss_pkg::DOMAIN_CTL0_OFS, paddr == pss_pkg::DOMAIN_CTL1_OFS: begin
          // Both domains always report on; power is never removed
          st_next.rdata = 32'(st_reg.ram_mode[paddr[2]]);
          st_next.rdata[pss_pkg::DOMAIN_ON_BIT] = 1'b1; // [RULE_06] [RULE_05]
          st_next.err = 1'b0;
        end
        ctl_hit: begin
          st_next.rdata = 32'(st_reg.tgt[ctl_c][ctl_s]);
          if (ctl_c == 1'b0 && ctl_s == 5'(pss_pkg::CPU_SLOT)) begin
            st_next.rdata[pss_pkg::LOCAL_RESET_BIT_BIT] = st_reg.local_reset_bit;
          end
          st_next.err = 1'b0;
        end
        stat_hit: begin
          st_next.rdata = 32'(s_cur[stat_c][stat_s]);
          st_next.err = 1'b0;
        end
        // Unused slot windows read zero without error
        ((paddr & pss_pkg::WINDOW_MASK) == pss_pkg::MOD_CTL_BASE)
          || ((paddr & pss_pkg::WINDOW_MASK) == pss_pkg::MOD_STAT_BASE): begin
          st_next.err = 1'b0; // [RULE_17]
        end
        default: begin
        end
      endcase
    end
    // Writes land on the completing edge only
    if (access_done && pwrite) begin
      unique case (1'b1)
        paddr == pss_pkg::INT_STAT_OFS: begin
          for (int c = 0; c < NC; c++) begin
            if (pwdata[c] && !(st_reg.busy_prev[c] && !busy_any[c])) begin
              st_next.int_stat[c] = 1'b0;
            end
          end
        end
        paddr == pss_pkg::INT_MASK_OFS: begin
          st_next.int_mask = pwdata[NC-1:0];
        end
        paddr == pss_pkg::DOMAIN_CTL0_OFS, paddr == pss_pkg::DOMAIN_CTL1_OFS: begin
          st_next.ram_mode[paddr[2]] = pwdata[1:0]; // [RULE_04]
        end
        ctl_hit: begin
          // Codes above auto wake are ignored
          if (wr_state <= pss_pkg::PSS_AUTO_WAKE) begin
            st_next.tgt[ctl_c][ctl_s] = wr_state; // [RULE_03]
          end
          if (ctl_c == 1'b0 && ctl_s == 5'(pss_pkg::CPU_SLOT)) begin
            st_next.local_reset_bit = pwdata[pss_pkg::LOCAL_RESET_BIT_BIT]; // [RULE_16] [RULE_03]
          end
        end
        default: begin
        end
      endcase
    end
    // Local reset waits until the processor reports no outstanding requests
    if (st_reg.local_reset_bit) begin
      st_next.cpu_rst_n = 1'b1; // [RULE_16]
    end else if (cpu_idle) begin
      st_next.cpu_rst_n = 1'b0; // [RULE_16]
    end
    st_next.irq = |(st_next.int_stat & st_next.int_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= RESET_VAL; // [RULE_11] [RULE_12]
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata = st_reg.rdata;
  assign pready = st_reg.ready;
  assign pslverr = st_reg.err;
  assign mod_clk_en0 = s_clk[0];
  assign mod_rst_n0 = s_rst_n[0];
  assign mod_clk_en1 = s_clk[1];
  assign mod_rst_n1 = s_rst_n[1];
  assign access_ack0 = s_ack[0];
  assign access_ack1 = s_ack[1];
  assign cpu_local_rst_n = st_reg.cpu_rst_n;
  assign ram_sleep_mode0 = st_reg.ram_mode[0];
  assign ram_sleep_mode1 = st_reg.ram_mode[1];
  assign irq = st_reg.irq;

endmodule // pss_ctrl

// ===== pss_ctrl_chk.sv
// Port checker of the power and sleep controller
module pss_ctrl_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cpu_idle,
  input wire logic cpu_local_rst_n,
  input wire logic [31:0] mod_clk_en0,
  input wire logic [31:0] mod_rst_n0,
  input wire logic [31:0] mod_clk_en1,
  input wire logic [31:0] mod_rst_n1,
  input wire logic [31:0] access_ack0,
  input wire logic [31:0] access_ack1
);
  // ==========================================================
  // Clocking
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Properties
  a_ready_wait:
    assert property ($rose(penable) && psel |-> !pready ##1 pready) else $error("late pready");
  a_ready_pulse:
    assert property (pready |=> !pready) else $error("pready too long");
  a_err_pulse:
    assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_unused_off:
    assert property (((mod_clk_en0 | mod_rst_n0) & ~32'h0000_7EFF) == 32'h0
      && ((mod_clk_en1 | mod_rst_n1) & ~32'h0732_3DEA) == 32'h0) else $error("unused slot driven");
  // Both edges in one cycle would glitch the module out of reset unclocked
  a_step_order:
    assert property (((mod_clk_en0 ^ $past(mod_clk_en0)) & (mod_rst_n0 ^ $past(mod_rst_n0))) == 0
      && ((mod_clk_en1 ^ $past(mod_clk_en1)) & (mod_rst_n1 ^ $past(mod_rst_n1))) == 0)
      else $error("clock and reset moved together");
  a_restrict_live:
    assert property ((mod_rst_n0 & 32'h0000_1C80) == 32'h0000_1C80
      && (mod_rst_n1 & 32'h0700_0000) == 32'h0700_0000) else $error("restricted slot in reset");
  a_ack_clock:
    assert property ((access_ack0 & ~mod_clk_en0) == 0 && (access_ack1 & ~mod_clk_en1) == 0)
      else $error("ack without clock");
  a_local_rst:
    assert property ($fell(cpu_local_rst_n) |-> $past(cpu_idle)) else $error("cpu reset while busy");
endmodule // pss_ctrl_chk

bind pss_ctrl pss_ctrl_chk chk_u (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .cpu_idle,
  .cpu_local_rst_n, .mod_clk_en0, .mod_rst_n0, .mod_clk_en1, .mod_rst_n1, .access_ack0,
  .access_ack1);

// ===== pss_periph_model.sv
// Peripheral side model: access requests and processor idle flag
module pss_periph_model (
  input wire logic pclk,
  input wire logic [31:0] access_ack0,
  input wire logic [31:0] access_ack1,
  output logic [31:0] access_req0,
  output logic [31:0] access_req1,
  output logic cpu_idle
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    access_req0 = 32'h0;
    access_req1 = 32'h0;
    cpu_idle = 1'b0;
  end
  // Processor owns its idle flag; reset must wait for it
  task automatic set_idle(input logic v);
    @(posedge pclk);
    cpu_idle <= v;
  endtask
  // Request held until acknowledged, then for hold more cycles
  task automatic access(input int b, input int s, input int hold, output bit ok);
    int n;
    n = 0;
    ok = 1'b0;
    @(posedge pclk);
    if (b == 0) access_req0[s] <= 1'b1;
    else access_req1[s] <= 1'b1;
    while (n < 20 && !ok) begin
      @(posedge pclk);
      n++;
      ok = (b == 0) ? access_ack0[s] === 1'b1 : access_ack1[s] === 1'b1;
    end
    repeat (hold) @(posedge pclk);
    if (b == 0) access_req0[s] <= 1'b0;
    else access_req1[s] <= 1'b0;
  endtask
endmodule // pss_periph_model

// ===== pss_pkg.sv
// Shared constants and types of the power and sleep controller
package pss_pkg;

  // ==========================================================
  // Module states, software visible codes
  typedef enum logic [2:0] {
    PSS_RST_CLK_OFF = 3'h0,
    PSS_RST_CLK_ON = 3'h1,
    PSS_DISABLE = 3'h2,
    PSS_ENABLE = 3'h3,
    PSS_AUTO_SLEEP = 3'h4,
    PSS_AUTO_WAKE = 3'h5
  } pss_mstate_t;

  // ==========================================================
  // Geometry
  localparam int unsigned NUM_CTRL = 2;
  localparam int unsigned NUM_SLOTS = 32;
  localparam int unsigned CPU_SLOT = 14;

  // ==========================================================
  // Per slot configuration masks, one bit per slot
  localparam logic [31:0] USED_MASK0 = 32'h0000_7EFF;
  localparam logic [31:0] ON_MASK0 = 32'h0000_1CC0;
  localparam logic [31:0] RESTRICT_MASK0 = 32'h0000_1C80;
  localparam logic [31:0] USED_MASK1 = 32'h0732_3DEA;
  localparam logic [31:0] ON_MASK1 = 32'h0700_0000;
  localparam logic [31:0] RESTRICT_MASK1 = 32'h0700_0000;

  // ==========================================================
  // Register map, byte addresses
  localparam logic [11:0] INT_STAT_OFS = 12'h000;
  localparam logic [11:0] INT_MASK_OFS = 12'h004;
  localparam logic [11:0] BUSY_STAT_OFS = 12'h00C;
  localparam logic [11:0] DOMAIN_CTL0_OFS = 12'h010;
  localparam logic [11:0] DOMAIN_CTL1_OFS = 12'h014;
  localparam logic [11:0] MOD_CTL_BASE = 12'h400;
  localparam logic [11:0] MOD_STAT_BASE = 12'h800;
  localparam logic [11:0] CTRL_STRIDE_MASK = 12'h100;
  localparam logic [11:0] WINDOW_MASK = 12'hE00;

  // Field positions and RAM mode reset value
  localparam int unsigned LOCAL_RESET_BIT_BIT = 8;
  localparam int unsigned DOMAIN_ON_BIT = 8;
  localparam logic [1:0] RAM_MODE_RESET = 2'h0;

endpackage : pss_pkg

// ===== pss_slot.sv
// One local sleep slot: clock enable and module reset of one module
module pss_slot #(
  parameter bit DEFAULT_ON = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] target,
  input wire logic access_req,
  output logic clk_en,
  output logic mod_rst_n,
  output logic [2:0] cur_state,
  output logic busy,
  output logic access_ack
);

  typedef struct packed {
    logic clk;
    logic rst;
    logic woke;
    logic [2:0] cur;
    logic busy;
    logic ack;
  } pss_slot_st_t;

  localparam pss_pkg::pss_mstate_t RST_ST =
    DEFAULT_ON ? pss_pkg::PSS_ENABLE : pss_pkg::PSS_RST_CLK_OFF;
  localparam pss_slot_st_t RESET_VAL = '{clk: DEFAULT_ON, rst: !DEFAULT_ON, woke: 1'b0,
    cur: RST_ST, busy: 1'b0, ack: 1'b0};

  pss_slot_st_t st_reg, st_next;
  logic want_rst, want_clk;

  // ==========================================================
  // Transition logic
  always_comb begin
    st_next = st_reg;
    want_rst = 1'b0;
    want_clk = 1'b0;
    unique case (target)
      pss_pkg::PSS_RST_CLK_OFF: begin
        want_rst = 1'b1;
      end
      pss_pkg::PSS_RST_CLK_ON: begin
        want_rst = 1'b1;
        want_clk = 1'b1;
      end
      pss_pkg::PSS_DISABLE: begin
        want_clk = 1'b0;
      end
      pss_pkg::PSS_ENABLE: begin
        want_clk = 1'b1;
      end
      pss_pkg::PSS_AUTO_SLEEP: begin
        want_clk = access_req; // [RULE_15]
      end
      pss_pkg::PSS_AUTO_WAKE: begin
        want_clk = st_reg.woke | access_req; // [RULE_15]
      end
      default: begin
        want_rst = st_reg.rst;
        want_clk = st_reg.clk;
      end
    endcase
    // First serviced access in auto wake keeps the clock on for good
    if (target == pss_pkg::PSS_AUTO_WAKE) begin
      if (access_req && st_reg.clk && !st_reg.rst) begin
        st_next.woke = 1'b1; // [RULE_15]
      end
    end else begin
      st_next.woke = 1'b0;
    end
    // Only one of clock and reset moves per cycle; clock first when it turns on,
    // so a reset edge always sees a running clock where possible
    if (st_reg.rst != want_rst && st_reg.clk != want_clk) begin
      if (want_clk) begin
        st_next.clk = 1'b1; // [RULE_18]
      end else begin
        st_next.rst = want_rst; // [RULE_18]
      end
    end else if (st_reg.rst != want_rst) begin
      st_next.rst = want_rst; // [RULE_13]
    end else if (st_reg.clk != want_clk) begin
      st_next.clk = want_clk; // [RULE_13]
    end
    st_next.busy = (st_next.rst != want_rst) || (st_next.clk != want_clk);
    if (!st_next.busy) begin
      st_next.cur = (target == pss_pkg::PSS_AUTO_WAKE && st_next.woke) ?
        pss_pkg::PSS_ENABLE : target;
    end
    // No acknowledge while the clock is about to stop or reset is about to rise
    st_next.ack = access_req && st_reg.clk && !st_reg.rst && st_next.clk && !st_next.rst;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= RESET_VAL; // [RULE_08] [RULE_09]
    end else begin
      st_reg <= st_next;
    end
  end

  assign clk_en = st_reg.clk; // [RULE_01]
  assign mod_rst_n = !st_reg.rst;
  assign cur_state = st_reg.cur;
  assign busy = st_reg.busy;
  assign access_ack = st_reg.ack;

endmodule // pss_slot
